// >>> synth_ctrl_map.svh
// Constants for the synthesizer control block
// Assumes inclusion by the package and the main module
`ifndef SYNTH_CTRL_MAP_SVH
`define SYNTH_CTRL_MAP_SVH
`define SHIFT_LEN        11
`define SEL_BIT          10
`define REF_LATCH_W      10
`define FB_LATCH_W       8
`define NDIV_LSB         0
`define NDIV_W           5
`define DAC_LSB          5
`define DAC_W            5
`define MDIV_LSB         0
`define MDIV_W           8
`define REF_LATCH_RST    10'h000
`define FB_LATCH_RST     8'h00
`endif

// >>> synth_ctrl_pkg.sv
// Types for the synthesizer control block
// Assumes synth_ctrl_map.svh is on the include path
package synth_ctrl_pkg;
`include "synth_ctrl_map.svh"
   typedef enum logic [1:0]
   {
      PFD_IDLE = 2'b00,
      PFD_UP   = 2'b01,
      PFD_BOTH = 2'b11,
      PFD_DOWN = 2'b10
   } pfd_state_t;
   typedef logic [`SHIFT_LEN-1:0] shift_word_t;
endpackage

// >>> sync_edge_if.sv
// Carrier between the main module and its pin synchroniser
// Assumes one clock domain
interface sync_edge_if;
   logic level;
   logic rise;
   logic fall;
   modport src (output level, output rise, output fall);
   modport dst (input level, input rise, input fall);
endinterface

// >>> pin_sync.sv
// Three-stage pin synchroniser with agreement on stages two and three
// Assumes the pin is asynchronous to sys_clk
module pin_sync
(
   input  wire logic sys_clk,
   input  wire logic rst_n,
   input  wire logic pinIn,
   sync_edge_if.src  edges
);
   logic stage1;
   logic stage2;
   logic stage3;
   logic settled;

   // Settled level moves only when stages two and three agree
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         stage1  <= 1'b1;
         stage2  <= 1'b1;
         stage3  <= 1'b1;
         settled <= 1'b1;
      end
      else
      begin
         stage1 <= pinIn;
         stage2 <= stage1;
         stage3 <= stage2;
         if (stage2 == stage3)
            settled <= stage3;
      end
   end

   assign edges.level = settled;
   assign edges.rise  = (stage2 == stage3) && stage3 && !settled;
   assign edges.fall  = (stage2 == stage3) && !stage3 && settled;
endmodule

// >>> synth_serial_divider_control.sv
// Serial programming, divider and detector control for the frequency synthesizer
// Assumes all pins are sampled on sys_clk; clock pins far below sys_clk/2
`include "synth_ctrl_map.svh"
module synth_serial_divider_control
   import synth_ctrl_pkg::*;
#(
   parameter int SHIFT_BITS = `SHIFT_LEN
)
(
   input  wire logic                   sys_clk,
   input  wire logic                   rst_n,
   input  wire logic                   serialClock,
   input  wire logic                   serial_in_line,
   input  wire logic                   serial_load_enable_n,
   input  wire logic                   code_rate_select,
   input  wire logic                   feedback_source_select,
   input  wire logic                   osc_bypass_select_n,
   input  wire logic                   test_osc_input,
   input  wire logic                   vcoClock,
   input  wire logic                   ref_clock_in,
   input  wire logic                   ext_feedback_in,
   input  wire logic                   detector_run,
   output logic                        osc_full_rate_out,
   output logic                        osc_full_rate_out_n,
   output logic                        low_rate_clock_out,
   output logic                        low_rate_clock_out_n,
   output logic                        code_rate_clock_out,
   output logic                        code_rate_clock_out_n,
   output logic                        fb_divided_out,
   output logic                        fb_divided_out_n,
   output logic                        pumpUpProbe,
   output logic                        pump_down_probe,
   output logic [`DAC_W-1:0]           dacCode,
   output logic                        latch_upset_flag
);
   import synth_ctrl_pkg::*;

   if (SHIFT_BITS != `SHIFT_LEN)
   begin : gBadLength
      $error("Shift register length must be eleven");
   end

   // =====================================================
   // Pin synchronisers
   // =====================================================
   sync_edge_if sclkS ();
   sync_edge_if senS ();
   sync_edge_if sdatS ();
   sync_edge_if tstS ();
   sync_edge_if vcoS ();
   sync_edge_if refS ();
   sync_edge_if extS ();
   sync_edge_if cselS ();
   sync_edge_if fselS ();
   sync_edge_if bselS ();
   sync_edge_if runS ();

   pin_sync uSclk (.sys_clk(sys_clk), .rst_n(rst_n), .pinIn(serialClock), .edges(sclkS));
   pin_sync uSen  (.sys_clk(sys_clk), .rst_n(rst_n), .pinIn(serial_load_enable_n), .edges(senS));
   pin_sync uSdat (.sys_clk(sys_clk), .rst_n(rst_n), .pinIn(serial_in_line), .edges(sdatS));
   pin_sync uTst  (.sys_clk(sys_clk), .rst_n(rst_n), .pinIn(test_osc_input), .edges(tstS));
   pin_sync uVco  (.sys_clk(sys_clk), .rst_n(rst_n), .pinIn(vcoClock), .edges(vcoS));
   pin_sync uRef  (.sys_clk(sys_clk), .rst_n(rst_n), .pinIn(ref_clock_in), .edges(refS));
   pin_sync uExt  (.sys_clk(sys_clk), .rst_n(rst_n), .pinIn(ext_feedback_in), .edges(extS));
   pin_sync uCsel (.sys_clk(sys_clk), .rst_n(rst_n), .pinIn(code_rate_select), .edges(cselS));
   pin_sync uFsel (.sys_clk(sys_clk), .rst_n(rst_n), .pinIn(feedback_source_select), .edges(fselS));
   pin_sync uBsel (.sys_clk(sys_clk), .rst_n(rst_n), .pinIn(osc_bypass_select_n), .edges(bselS));
   pin_sync uRun  (.sys_clk(sys_clk), .rst_n(rst_n), .pinIn(detector_run), .edges(runS));

   // =====================================================
   // Serial shift register and latches
   // =====================================================
   shift_word_t             shiftReg;
   logic [`REF_LATCH_W-1:0] refLatch;
   logic [`REF_LATCH_W-1:0] refShadow;
   logic [`FB_LATCH_W-1:0]  fbLatch;
   logic [`FB_LATCH_W-1:0]  fbShadow;

   wire shiftNow  = sclkS.rise && !senS.level;
   wire commitNow = senS.rise;
   wire selB      = shiftReg[`SEL_BIT];
   wire shift_word_t next_shift = {shiftReg[`SHIFT_LEN-2:0], sdatS.level};

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
         shiftReg <= '0;
      else if (shiftNow)
         shiftReg <= next_shift;
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         refLatch  <= `REF_LATCH_RST;
         refShadow <= `REF_LATCH_RST;
         fbLatch   <= `FB_LATCH_RST;
         fbShadow  <= `FB_LATCH_RST;
      end
      else if (commitNow)
      begin
         if (!selB)
         begin
            refLatch  <= shiftReg[`REF_LATCH_W-1:0];
            refShadow <= shiftReg[`REF_LATCH_W-1:0];
         end
         else
         begin
            fbLatch  <= shiftReg[`FB_LATCH_W-1:0];
            fbShadow <= shiftReg[`FB_LATCH_W-1:0];
         end
      end
   end

   wire [`NDIV_W-1:0] nField = refLatch[`NDIV_LSB +: `NDIV_W];
   wire [`MDIV_W-1:0] mField = fbLatch[`MDIV_LSB +: `MDIV_W];
   wire [`DAC_W-1:0]  dacField = refLatch[`DAC_LSB +: `DAC_W];
   wire               upset = (refLatch != refShadow) || (fbLatch != fbShadow);

   // =====================================================
   // Oscillator source and output dividers
   // =====================================================
   // Bypass low selects the test oscillator
   wire oscRise = bselS.level ? vcoS.rise : tstS.rise;

   // Terminal-count divider step, divides by field plus one
   function automatic logic [7:0] div_step(input logic [7:0] cnt, input logic [7:0] lim);
      div_step = (cnt >= lim) ? 8'h00 : 8'(cnt + 8'h01);
   endfunction

   logic       fullPhase;
   logic [1:0] lowCnt;
   logic       lowPhase;
   logic       codePhase;

   wire [1:0] lowLim = cselS.level ? 2'h2 : 2'h1;
   wire       lowWrap = (lowCnt >= lowLim);

   // Full-rate toggles per oscillator edge; the rate select has no effect on it
   // Low-rate divides full-rate by 2 or 3; code-rate by 1 or 2
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         fullPhase <= 1'b0;
         lowCnt    <= 2'h0;
         lowPhase  <= 1'b0;
         codePhase <= 1'b0;
      end
      else if (oscRise)
      begin
         fullPhase <= !fullPhase;
         if (lowWrap)
            lowCnt <= 2'h0;
         else
            lowCnt <= 2'(lowCnt + 2'h1);
         if (lowWrap)
            lowPhase <= !lowPhase;
         if (!cselS.level)
            codePhase <= !fullPhase;
         else if (!fullPhase)
            codePhase <= !codePhase;
      end
   end

   wire codeRise = oscRise && !fullPhase && (!cselS.level || !codePhase);

   // =====================================================
   // Reference and feedback dividers
   // =====================================================
   logic [`NDIV_W-1:0] nCnt;
   logic [`MDIV_W-1:0] mCnt;
   logic               mOut;

   wire nWrap = (nCnt >= nField);
   wire mWrap = (mCnt >= mField);
   wire [`MDIV_W-1:0] nextM = div_step(mCnt, mField);
   wire refPulse = refS.rise && nWrap;
   wire intFbPulse = codeRise && mWrap;
   wire fbPulse = fselS.level ? intFbPulse : extS.rise;

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         nCnt <= '0;
         mCnt <= '0;
         mOut <= 1'b0;
      end
      else
      begin
         if (refS.rise)
            nCnt <= nWrap ? '0 : 5'(nCnt + 5'h01);
         if (codeRise)
         begin
            mCnt <= nextM;
            mOut <= (nextM <= (mField >> 1));
         end
      end
   end

   // =====================================================
   // Phase/frequency detector
   // =====================================================
   pfd_state_t pfdState;
   pfd_state_t next_pfd;

   always_comb
   begin
      next_pfd = pfdState;
      case (pfdState)
         PFD_IDLE:
            if (refPulse && fbPulse)
               next_pfd = PFD_BOTH;
            else if (refPulse)
               next_pfd = PFD_UP;
            else if (fbPulse)
               next_pfd = PFD_DOWN;
         PFD_UP:
            if (fbPulse)
               next_pfd = PFD_BOTH;
         PFD_DOWN:
            if (refPulse)
               next_pfd = PFD_BOTH;
         PFD_BOTH:
            next_pfd = PFD_IDLE;
         default:
            next_pfd = PFD_IDLE;
      endcase
      if (!runS.level)
         next_pfd = PFD_IDLE;
   end

   wire upReq = (next_pfd == PFD_UP) || (next_pfd == PFD_BOTH);
   wire dnReq = (next_pfd == PFD_DOWN) || (next_pfd == PFD_BOTH);

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
         pfdState <= PFD_IDLE;
      else
         pfdState <= next_pfd;
   end

   // =====================================================
   // Registered outputs
   // =====================================================
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         osc_full_rate_out     <= 1'b0;
         osc_full_rate_out_n   <= 1'b1;
         low_rate_clock_out    <= 1'b0;
         low_rate_clock_out_n  <= 1'b1;
         code_rate_clock_out   <= 1'b0;
         code_rate_clock_out_n <= 1'b1;
         fb_divided_out        <= 1'b0;
         fb_divided_out_n      <= 1'b1;
         pumpUpProbe           <= 1'b0;
         pump_down_probe       <= 1'b0;
         dacCode               <= '0;
         latch_upset_flag      <= 1'b1;
      end
      else
      begin
         osc_full_rate_out     <= fullPhase;
         osc_full_rate_out_n   <= !fullPhase;
         low_rate_clock_out    <= lowPhase;
         low_rate_clock_out_n  <= !lowPhase;
         code_rate_clock_out   <= codePhase;
         code_rate_clock_out_n <= !codePhase;
         fb_divided_out        <= (mField == '0) ? codePhase : mOut;
         fb_divided_out_n      <= (mField == '0) ? !codePhase : !mOut;
         pumpUpProbe           <= upReq;
         pump_down_probe       <= dnReq;
         dacCode               <= dacField;
         latch_upset_flag      <= !upset;
      end
   end
endmodule

// >>> synth_ctrl_sva.sv
// Checker for the synthesizer control block
// Assumes a bind onto synth_serial_divider_control
module synth_ctrl_sva
#(
   parameter int SHIFT_BITS = 11
)
(
   input wire logic       sys_clk,
   input wire logic       rst_n,
   input wire logic       serial_load_enable_n,
   input wire logic       detector_run,
   input wire logic       osc_full_rate_out,
   input wire logic       osc_full_rate_out_n,
   input wire logic       low_rate_clock_out,
   input wire logic       low_rate_clock_out_n,
   input wire logic       code_rate_clock_out,
   input wire logic       code_rate_clock_out_n,
   input wire logic       fb_divided_out,
   input wire logic       fb_divided_out_n,
   input wire logic       pumpUpProbe,
   input wire logic       pump_down_probe,
   input wire logic [4:0] dacCode,
   input wire logic       latch_upset_flag
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // =====================================
   // Reset, flag, detector step, DAC commit and clock pair checks
   sequence bothPumps;
      pumpUpProbe && pump_down_probe;
   endsequence
   sequence runOff;
      !detector_run [*8];
   endsequence
   a_reset_outputs: assert property (disable iff (1'b0) !rst_n |=> latch_upset_flag && dacCode == 5'h00
      && !pumpUpProbe && !pump_down_probe && !osc_full_rate_out && osc_full_rate_out_n)
      else $error("outputs not at reset values");
   a_flag_rests: assert property (latch_upset_flag)
      else $error("upset flag dropped without corruption");
   a_both_clear: assert property (bothPumps |=> !pumpUpProbe && !pump_down_probe)
      else $error("pumps not cleared after both asserted");
   a_run_off: assert property (runOff |-> !pumpUpProbe && !pump_down_probe)
      else $error("pump active while detector stopped");
   a_up_holds: assert property ($fell(pumpUpProbe) |-> $past(pump_down_probe) || !detector_run)
      else $error("pump up dropped without clear");
   a_dac_commit: assert property ($changed(dacCode) |-> $past(serial_load_enable_n, 3)
      && !$past(serial_load_enable_n, 8))
      else $error("dac code changed outside a commit");
   a_clock_pairs: assert property (osc_full_rate_out_n != osc_full_rate_out &&
      low_rate_clock_out_n != low_rate_clock_out && code_rate_clock_out_n != code_rate_clock_out)
      else $error("clock output pair not complementary");
   a_fb_pair: assert property (fb_divided_out_n != fb_divided_out)
      else $error("divided feedback pair not complementary");
endmodule

// >>> host_serial_model.sv
// Host model driving the three-wire serial programming port
// Assumes the bench calls its tasks; pins move on sys_clk falling edges
module host_serial_model
(
   input  wire logic sys_clk,
   output logic      serialClock,
   output logic      serial_in_line,
   output logic      serial_load_enable_n
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      serialClock = 1'b0;
      serial_in_line = 1'b1;
      serial_load_enable_n = 1'b1;
   end
   task automatic hold(input int n);
      repeat (n) @(negedge sys_clk);
   endtask
   // Leading bits of word, select bit first; gap sets the pace
   task automatic frame(input logic [10:0] word, input int bits, input int gap);
      hold(gap);
      serial_load_enable_n = 1'b0;
      for (int i = 10; i > 10 - bits; i--)
      begin
         hold(gap);
         serial_in_line = word[i];
         hold(gap);
         serialClock = 1'b1;
         hold(gap);
         serialClock = 1'b0;
      end
      hold(gap);
      serial_load_enable_n = 1'b1;
      serial_in_line = ~serial_in_line;
   endtask
   // Deliberate zero shifts while the port is disabled
   task automatic stray(input int n);
      serial_in_line = 1'b0;
      repeat (n)
      begin
         hold(4);
         serialClock = 1'b1;
         hold(4);
         serialClock = 1'b0;
      end
   endtask
endmodule

// >>> testbench.sv
// Self-checking bench for the synthesizer control block
// Assumes design, host model and checker compiled first
`define CHK(got, exp) begin cmpCount++; if ((got) !== (exp)) begin failCount++; \
   $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic       sys_clk, rst_n, serialClock, serial_in_line, serial_load_enable_n, code_rate_select;
   logic       feedback_source_select, osc_bypass_select_n, test_osc_input, ref_clock_in;
   logic       ext_feedback_in, detector_run, osc_full_rate_out, osc_full_rate_out_n, low_rate_clock_out;
   logic       low_rate_clock_out_n, code_rate_clock_out, code_rate_clock_out_n, fb_divided_out;
   logic       fb_divided_out_n, pumpUpProbe, pump_down_probe, latch_upset_flag;
   logic [4:0] dacCode;
   logic [3:0] outs, prevOuts;
   int         rises [4];
   int         failCount, cmpCount;
   synth_serial_divider_control i_synth_serial_divider_control
   (
      .sys_clk(sys_clk), .rst_n(rst_n), .serialClock(serialClock), .serial_in_line(serial_in_line),
      .serial_load_enable_n(serial_load_enable_n), .code_rate_select(code_rate_select),
      .feedback_source_select(feedback_source_select), .osc_bypass_select_n(osc_bypass_select_n),
      .test_osc_input(test_osc_input), .vcoClock(1'b0), .ref_clock_in(ref_clock_in),
      .ext_feedback_in(ext_feedback_in), .detector_run(detector_run), .osc_full_rate_out(osc_full_rate_out),
      .osc_full_rate_out_n(osc_full_rate_out_n), .low_rate_clock_out(low_rate_clock_out),
      .low_rate_clock_out_n(low_rate_clock_out_n), .code_rate_clock_out(code_rate_clock_out),
      .code_rate_clock_out_n(code_rate_clock_out_n), .fb_divided_out(fb_divided_out),
      .fb_divided_out_n(fb_divided_out_n), .pumpUpProbe(pumpUpProbe), .pump_down_probe(pump_down_probe),
      .dacCode(dacCode), .latch_upset_flag(latch_upset_flag)
   );
   host_serial_model i_host_serial_model
   (
      .sys_clk(sys_clk), .serialClock(serialClock), .serial_in_line(serial_in_line),
      .serial_load_enable_n(serial_load_enable_n)
   );
   initial
   begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   // =====================================
   // Rising-edge counters on the clock outputs
   assign outs = {fb_divided_out, code_rate_clock_out, low_rate_clock_out, osc_full_rate_out};
   always @(negedge sys_clk)
   begin
      for (int k = 0; k < 4; k++)
         if (outs[k] && !prevOuts[k])
            rises[k]++;
      prevOuts <= outs;
   end
   function automatic bit near(input int got, input int want);
      return got >= want - 1 && got <= want + 1;
   endfunction
   task automatic wait_cycles(input int n);
      repeat (n) @(negedge sys_clk);
   endtask
   task automatic osc_run(input int n);
      @(posedge sys_clk);
      rises = '{default: 0};
      repeat (n)
      begin
         wait_cycles(1);
         test_osc_input = 1'b1;
         wait_cycles(6);
         test_osc_input = 1'b0;
         wait_cycles(5);
      end
      wait_cycles(10);
   endtask
   task automatic pin_pulse(input bit toRef, input int k);
      repeat (k)
      begin
         wait_cycles(1);
         ref_clock_in = toRef;
         ext_feedback_in = !toRef;
         wait_cycles(4);
         ref_clock_in = 1'b0;
         ext_feedback_in = 1'b0;
         wait_cycles(4);
      end
      wait_cycles(8);
   endtask
   // =====================================
   // Scenarios
   task automatic test_program();
      i_host_serial_model.frame(11'h3E2, 11, 4);
      wait_cycles(8);
      `CHK(dacCode, 5'h1F)
      i_host_serial_model.stray(11);
      i_host_serial_model.frame(11'h000, 0, 4);
      wait_cycles(8);
      `CHK(dacCode, 5'h1F)
      i_host_serial_model.frame(11'h202, 11, 8);
      wait_cycles(8);
      `CHK(dacCode, 5'h10)
      i_host_serial_model.frame(11'h701, 11, 4);
      wait_cycles(8);
      `CHK(dacCode, 5'h10)
      `CHK(latch_upset_flag, 1'b1)
      $display("test program done");
   endtask
   task automatic test_osc();
      osc_run(8);
      `CHK(rises[0], 0)
      osc_bypass_select_n = 1'b0;
      osc_run(48);
      `CHK(near(rises[0], 24), 1'b1)
      `CHK(near(rises[1], rises[0] / 2), 1'b1)
      `CHK(near(rises[2], rises[0]), 1'b1)
      `CHK(near(rises[3], rises[2] / 2), 1'b1)
      code_rate_select = 1'b1;
      osc_run(48);
      `CHK(near(rises[1], rises[0] / 3), 1'b1)
      `CHK(near(rises[2], rises[0] / 2), 1'b1)
      `CHK(near(rises[3], rises[2] / 2), 1'b1)
      osc_bypass_select_n = 1'b1;
      $display("test osc done");
   endtask
   task automatic test_detector();
      detector_run = 1'b1;
      feedback_source_select = 1'b1;
      pin_pulse(1'b0, 1);
      `CHK(pump_down_probe, 1'b0)
      feedback_source_select = 1'b0;
      pin_pulse(1'b0, 1);
      `CHK({pumpUpProbe, pump_down_probe}, 2'b01)
      pin_pulse(1'b1, 3);
      `CHK({pumpUpProbe, pump_down_probe}, 2'b00)
      pin_pulse(1'b1, 2);
      `CHK(pumpUpProbe, 1'b0)
      pin_pulse(1'b1, 1);
      `CHK({pumpUpProbe, pump_down_probe}, 2'b10)
      detector_run = 1'b0;
      wait_cycles(10);
      `CHK(pumpUpProbe, 1'b0)
      pin_pulse(1'b1, 3);
      `CHK(pumpUpProbe, 1'b0)
      $display("test detector done");
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", cmpCount, failCount);
      if (failCount == 0 && cmpCount > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial
   begin
      rst_n = 1'b0;
      code_rate_select = 1'b0;
      feedback_source_select = 1'b0;
      osc_bypass_select_n = 1'b1;
      test_osc_input = 1'b0;
      ref_clock_in = 1'b0;
      ext_feedback_in = 1'b0;
      detector_run = 1'b0;
      wait_cycles(2);
      rst_n = 1'b1;
      wait_cycles(4);
      test_program();
      test_osc();
      test_detector();
      report_and_stop();
   end
   initial
   begin
      repeat (10000) @(posedge sys_clk);
      failCount++;
      report_and_stop();
   end
endmodule
bind synth_serial_divider_control synth_ctrl_sva #(.SHIFT_BITS(SHIFT_BITS)) i_synth_ctrl_sva
(
   .sys_clk(sys_clk), .rst_n(rst_n), .serial_load_enable_n(serial_load_enable_n), .detector_run(detector_run),
   .osc_full_rate_out(osc_full_rate_out), .osc_full_rate_out_n(osc_full_rate_out_n),
   .low_rate_clock_out(low_rate_clock_out), .low_rate_clock_out_n(low_rate_clock_out_n),
   .code_rate_clock_out(code_rate_clock_out), .code_rate_clock_out_n(code_rate_clock_out_n),
   .fb_divided_out(fb_divided_out), .fb_divided_out_n(fb_divided_out_n), .pumpUpProbe(pumpUpProbe),
   .pump_down_probe(pump_down_probe), .dacCode(dacCode), .latch_upset_flag(latch_upset_flag)
);
